//--- rtl/bms_consts.svh
// Timing constants of the ballast mode and strike timer.
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

// ----------------------------------------------------------------------------
// System clock
// ----------------------------------------------------------------------------
`define BMS_CLK_HZ          50000000
`define BMS_CLK_PER_MS      (`BMS_CLK_HZ / 1000)
`define BMS_CLK_PER_US      (`BMS_CLK_HZ / 1000000)

// ----------------------------------------------------------------------------
// Strike timer time base
// ----------------------------------------------------------------------------
`define BMS_OSC_PERIOD_MS   666
`define BMS_OSC_DIV         128
`define BMS_TICK_CYCLES     (`BMS_OSC_PERIOD_MS * `BMS_CLK_PER_MS)

// ----------------------------------------------------------------------------
// Strike intervals and fault times
// ----------------------------------------------------------------------------
`define BMS_STRIKE_ON_MS    21000
`define BMS_STRIKE_OFF_MS   64000
`define BMS_STRIKE_FAULT_MS 787000
`define BMS_UV_FAULT_MS     197000
`define BMS_ON_TICKS        ((`BMS_STRIKE_ON_MS + `BMS_OSC_PERIOD_MS / 2) / `BMS_OSC_PERIOD_MS)
`define BMS_FAULT_TICKS     (`BMS_STRIKE_FAULT_MS / `BMS_OSC_PERIOD_MS)
`define BMS_UV_TICKS        (`BMS_UV_FAULT_MS / `BMS_OSC_PERIOD_MS)

// ----------------------------------------------------------------------------
// Bridge dead time
// ----------------------------------------------------------------------------
`define BMS_DEAD_NS         1000
`define BMS_DEAD_CYCLES     ((`BMS_DEAD_NS * `BMS_CLK_PER_US + 999) / 1000)

`endif

//--- rtl/bms_pkg.sv
// Types shared by the ballast mode and strike timer.
package bms_pkg;

  // --------------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    bms_lockout,
    bms_ignite,
    bms_run,
    bms_fault
  } bms_mode_t;

endpackage : bms_pkg

//--- rtl/bms_tick_if.sv
// Carrier between the mode logic and the strike time base divider.
`timescale 1ns/1ps
`default_nettype none

interface bms_tick_if;
  logic run;   // Time base runs while high, held cleared while low.
  logic tick;  // One-cycle pulse at each oscillator period.

  modport src  (input run, output tick);
  modport sink (output run, input tick);
endinterface : bms_tick_if

`default_nettype wire

//--- rtl/bms_tick_div.sv
// Divider that turns the system clock into the strike oscillator tick.
`timescale 1ns/1ps
`default_nettype none

module bms_tick_div #(
  parameter int unsigned TICK_CYCLES = 33300000
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  bms_tick_if.src    tb
);

  localparam int unsigned W = $clog2(TICK_CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         wrap;

  // ----------------------------------------------------------------------------
  // Count and wrap
  // ----------------------------------------------------------------------------
  // Holding the count at zero while stopped keeps the first period whole.
  assign wrap     = tb.run && (cnt_reg == LAST);
  assign cnt_next = (!tb.run || wrap) ? '0 : cnt_reg + W'(1);
  assign tb.tick  = tick_reg;

  // Counter and tick flops.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= wrap;
    end
  end

endmodule : bms_tick_div

`default_nettype wire

//--- rtl/bms_mode_timer.sv
// Mode sequencer, strike timer and bridge phase logic of the ballast controller.
`timescale 1ns/1ps
`default_nettype none
`include "bms_consts.svh"

// Operation
// - The strike timer starts counting only when the controller first enters ignition mode.
// - The strike time base is an oscillator tick of about 666 ms, divided by 128 into one on/off cycle.
// - While the lamp is unlit the strike gate is high for about 21 s, then low for about 64 s, repeating.
// - After about 787 s of striking without ignition the controller enters fault mode and latches off.
// - When lamp voltage drops below the lamp high threshold the lamp counts as lit, the timer stops, the gate is low.
// - Lockout ends only with supply at its start threshold and fault clear low; then the bridge starts.
// - In supply lockout the bridge outputs and the buck are off.
// - In supply lockout the strike timer and its clock stop, counters are cleared and the fault latch clears.
// - In general mode the comparators choose the state, which gates the buck, counts faults or shuts down.
module bms_mode_timer
  import bms_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BMS_TICK_CYCLES,
  parameter int unsigned DEAD_CYCLES = `BMS_DEAD_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic supply_start_threshold,
  input  wire logic fault_clear_hi_in,
  input  wire logic lamp_volt_hi_in,
  input  wire logic lamp_volt_lo_in,
  input  wire logic lamp_volt_limit_in,
  input  wire logic lamp_amp_in,
  input  wire logic bridge_osc_cap,
  output logic      strike_gate_out,
  output logic      bridge_hi1_drive,
  output logic      bridge_lo1_drive,
  output logic      bridge_hi2_drive,
  output logic      bridge_lo2_drive,
  output logic      buck_drive_en,
  output logic      supply_lockout_mode,
  output logic      fault_mode,
  output logic      lamp_ignited
);

  localparam int   NSYNC     = 7;
  localparam int   DW        = $clog2(DEAD_CYCLES + 1);
  localparam logic [6:0]  ON_TICKS    = 7'(`BMS_ON_TICKS);
  localparam logic [10:0] FAULT_TICKS = 11'(`BMS_FAULT_TICKS);
  localparam logic [10:0] UV_TICKS    = 11'(`BMS_UV_TICKS);
  localparam logic [DW-1:0] DEAD_LOAD = DW'(DEAD_CYCLES);

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic             osc_prev_reg;

  assign raw_in = {bridge_osc_cap, lamp_amp_in, lamp_volt_limit_in, lamp_volt_lo_in,
                   lamp_volt_hi_in, fault_clear_hi_in, supply_start_threshold};

  // Two flops per input, plus a third on the oscillator input; the logic reads the second stage and that third flop.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= raw_in;
      sync2_reg    <= sync1_reg;
      osc_prev_reg <= sync2_reg[6];
    end
  end

  logic s_supply;
  logic s_clear_hi;
  logic s_volt_hi;
  logic s_volt_lo;
  logic s_volt_lim;
  logic s_amp;
  logic osc_edge;

  assign s_supply   = sync2_reg[0];
  assign s_clear_hi = sync2_reg[1];
  assign s_volt_hi  = sync2_reg[2];
  assign s_volt_lo  = sync2_reg[3];
  assign s_volt_lim = sync2_reg[4];
  assign s_amp      = sync2_reg[5];
  assign osc_edge   = sync2_reg[6] && !osc_prev_reg;

  // ----------------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------------
  bms_mode_t mode_reg;
  bms_mode_t mode_next;
  logic      tick;
  logic      active;

  bms_tick_if tb_if ();

  assign active    = (mode_reg == bms_ignite) || (mode_reg == bms_run);
  assign tb_if.run = active;
  assign tick      = tb_if.tick;

  bms_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick_div (
    .clk    (clk),
    .arst_n (arst_n),
    .tb     (tb_if.src)
  );

  // ----------------------------------------------------------------------------
  // Strike and fault counters
  // ----------------------------------------------------------------------------
  logic [6:0]  phase_reg;
  logic [6:0]  phase_next;
  logic [10:0] strike_reg;
  logic [10:0] strike_next;
  logic [10:0] uv_reg;
  logic [10:0] uv_next;
  logic        strike_tick;
  logic        strike_timeout;
  logic        uv_timeout;

  // The phase counter wraps at 128 ticks, which forms one on plus off cycle.
  assign strike_tick    = (mode_reg == bms_ignite) && tick;
  assign phase_next     = !active ? '0 : (strike_tick ? phase_reg + 7'd1 : phase_reg);
  assign strike_next    = !active ? '0 : (strike_tick ? strike_reg + 11'd1 : strike_reg);
  assign strike_timeout = strike_tick && (strike_reg == FAULT_TICKS - 11'd1);

  // Under-voltage time is counted only while lit and low, and forgiven once it recovers.
  assign uv_next    = (mode_reg != bms_run || !s_volt_lo) ? '0 :
                      (tick ? uv_reg + 11'd1 : uv_reg);
  assign uv_timeout = (mode_reg == bms_run) && s_volt_lo && tick &&
                      (uv_reg == UV_TICKS - 11'd1);

  // ----------------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------------
  // Loss of supply overrides every mode, since lockout acts as the reset of the sequencer.
  always_comb
  begin
    mode_next = mode_reg;
    if (!s_supply)
    begin
      mode_next = bms_lockout;
    end
    else
    begin
      case (mode_reg)
        bms_lockout:
        begin
          if (!s_clear_hi)
            mode_next = bms_ignite;
        end
        bms_ignite:
        begin
          if (!s_volt_hi)
            mode_next = bms_run;
          else if (strike_timeout)
            mode_next = bms_fault;
        end
        bms_run:
        begin
          if (uv_timeout)
            mode_next = bms_fault;
          else if (s_volt_hi)
            mode_next = bms_ignite;
        end
        bms_fault:
        begin
          if (s_clear_hi)
            mode_next = bms_lockout;
        end
        default:
        begin
          mode_next = bms_lockout;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Bridge phase and dead time
  // ----------------------------------------------------------------------------
  logic          bphase_reg;
  logic          bphase_next;
  logic [DW-1:0] dead_reg;
  logic [DW-1:0] dead_next;
  logic          in_dead;

  // Each rising oscillator edge flips the diagonal pair and opens a fresh dead time.
  assign bphase_next = !active ? 1'b0 : (osc_edge ? !bphase_reg : bphase_reg);
  assign dead_next   = !active ? DEAD_LOAD :
                       (osc_edge ? DEAD_LOAD : (dead_reg != '0 ? dead_reg - DW'(1) : dead_reg));
  assign in_dead     = (dead_reg != '0) || osc_edge;

  // ----------------------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------------------
  logic drive_ok;
  logic gate_next;
  logic buck_next;

  // The strike gate is held low during dead time so an ignition pulse never hits a floating bridge.
  assign drive_ok  = (mode_next == bms_ignite || mode_next == bms_run) && active && !in_dead;
  assign gate_next = (mode_next == bms_ignite) && (mode_reg == bms_ignite) && !in_dead &&
                     (phase_next < ON_TICKS);
  assign buck_next = (mode_next == bms_ignite || mode_next == bms_run) &&
                     !s_volt_lim && !s_amp;

  // ----------------------------------------------------------------------------
  // State and output flops
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg   <= bms_lockout;
      phase_reg  <= '0;
      strike_reg <= '0;
      uv_reg     <= '0;
      bphase_reg <= 1'b0;
      dead_reg   <= DEAD_LOAD;
    end
    else
    begin
      mode_reg   <= mode_next;
      phase_reg  <= phase_next;
      strike_reg <= strike_next;
      uv_reg     <= uv_next;
      bphase_reg <= bphase_next;
      dead_reg   <= dead_next;
    end
  end

  // Every output is a flop, so pins never glitch on decode hazards.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strike_gate_out     <= 1'b0;
      bridge_hi1_drive    <= 1'b0;
      bridge_lo1_drive    <= 1'b0;
      bridge_hi2_drive    <= 1'b0;
      bridge_lo2_drive    <= 1'b0;
      buck_drive_en       <= 1'b0;
      supply_lockout_mode <= 1'b1;
      fault_mode          <= 1'b0;
      lamp_ignited        <= 1'b0;
    end
    else
    begin
      strike_gate_out     <= gate_next;
      bridge_hi1_drive    <= drive_ok && bphase_next;
      bridge_lo1_drive    <= drive_ok && !bphase_next;
      bridge_hi2_drive    <= drive_ok && !bphase_next;
      bridge_lo2_drive    <= drive_ok && bphase_next;
      buck_drive_en       <= buck_next;
      supply_lockout_mode <= (mode_next == bms_lockout);
      fault_mode          <= (mode_next == bms_fault);
      lamp_ignited        <= (mode_next == bms_run);
    end
  end

endmodule : bms_mode_timer

`default_nettype wire

//--- dv/bms_mode_timer_asserts.sv
// Port-level assertions for the ballast mode and strike timer.
`timescale 1ns/1ps
`default_nettype none

module bms_mode_timer_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_start_threshold,
  input wire logic fault_clear_hi_in,
  input wire logic lamp_volt_hi_in,
  input wire logic lamp_volt_lo_in,
  input wire logic lamp_volt_limit_in,
  input wire logic lamp_amp_in,
  input wire logic bridge_osc_cap,
  input wire logic strike_gate_out,
  input wire logic bridge_hi1_drive,
  input wire logic bridge_lo1_drive,
  input wire logic bridge_hi2_drive,
  input wire logic bridge_lo2_drive,
  input wire logic buck_drive_en,
  input wire logic supply_lockout_mode,
  input wire logic fault_mode,
  input wire logic lamp_ignited
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // All checks share the one clock; reset silences them.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_lockout_all_off: assert property (supply_lockout_mode |->
    !(bridge_hi1_drive || bridge_lo1_drive || bridge_hi2_drive || bridge_lo2_drive || buck_drive_en))
    else $error("power stage on in lockout");
  a_lockout_no_strike: assert property (supply_lockout_mode |-> !strike_gate_out && !fault_mode)
    else $error("strike or fault active in lockout");
  a_clear_holds_lock: assert property (fault_clear_hi_in [*3] ##1 supply_lockout_mode |=> supply_lockout_mode)
    else $error("lockout left with fault clear high");
  a_supply_loss_lock: assert property (!supply_start_threshold [*3] |=> supply_lockout_mode)
    else $error("no lockout after supply loss");
  a_bridge_starts: assert property ($fell(supply_lockout_mode) |-> ##[0:20]
    (bridge_lo1_drive || bridge_hi1_drive || supply_lockout_mode)) else $error("bridge did not start");
  a_bridge_diagonal: assert property (bridge_hi1_drive == bridge_lo2_drive && bridge_lo1_drive == bridge_hi2_drive
    && !(bridge_hi1_drive && bridge_lo1_drive)) else $error("bridge diagonals inconsistent");
  a_gate_dead_low: assert property (strike_gate_out |-> bridge_hi1_drive || bridge_lo1_drive)
    else $error("strike gate high during bridge dead time");
  a_lit_gate_low: assert property (lamp_ignited |-> !strike_gate_out)
    else $error("strike gate high with lamp lit");
  a_lit_cause: assert property ($rose(lamp_ignited) |-> !$past(lamp_volt_hi_in, 3))
    else $error("lamp lit without low lamp voltage");
  a_fault_latched: assert property ((!fault_clear_hi_in && supply_start_threshold) [*3] ##1
    (fault_mode && !fault_clear_hi_in) |=> fault_mode) else $error("fault latch lost");

  // Main scenarios reached.
  c_gate_rise: cover property ($rose(strike_gate_out));
  c_fault_rise: cover property ($rose(fault_mode));
  c_lit_rise: cover property ($rose(lamp_ignited));
endmodule : bms_mode_timer_asserts

bind bms_mode_timer bms_mode_timer_asserts bms_mode_timer_asserts_i (
  .clk(clk), .arst_n(arst_n), .supply_start_threshold(supply_start_threshold),
  .fault_clear_hi_in(fault_clear_hi_in), .lamp_volt_hi_in(lamp_volt_hi_in), .lamp_volt_lo_in(lamp_volt_lo_in),
  .lamp_volt_limit_in(lamp_volt_limit_in), .lamp_amp_in(lamp_amp_in), .bridge_osc_cap(bridge_osc_cap),
  .strike_gate_out(strike_gate_out), .bridge_hi1_drive(bridge_hi1_drive), .bridge_lo1_drive(bridge_lo1_drive),
  .bridge_hi2_drive(bridge_hi2_drive), .bridge_lo2_drive(bridge_lo2_drive), .buck_drive_en(buck_drive_en),
  .supply_lockout_mode(supply_lockout_mode), .fault_mode(fault_mode), .lamp_ignited(lamp_ignited));

`default_nettype wire

//--- dv/bms_lamp_model.sv
// Behavioural lamp, ignition switch and bridge oscillator comparator.
`timescale 1ns/1ps
`default_nettype none

module bms_lamp_model #(
  parameter int OSC_HALF  = 500,
  parameter int LIGHT_CYC = 50
) (
  input  wire logic clk,
  input  wire logic strike_gate_out,
  input  wire logic light_en,
  output var logic  lamp_volt_hi_in,
  output var logic  bridge_osc_cap
);
  int osc_cnt;
  int hit_cnt;

  initial
  begin
    osc_cnt = 0;
    hit_cnt = 0;
    lamp_volt_hi_in = 1'b1;
    bridge_osc_cap = 1'b0;
  end

  // Levels move at the falling edge so the design never samples a changing pin.
  // A lamp only lights after a sustained strike, which is why brief gate glitches do not count.
  always @(negedge clk)
  begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1)
      bridge_osc_cap <= ~bridge_osc_cap;
    hit_cnt <= (light_en && strike_gate_out) ? hit_cnt + 1 : 0;
    if (!light_en)
      lamp_volt_hi_in <= 1'b1;
    else if (hit_cnt >= LIGHT_CYC)
      lamp_volt_hi_in <= 1'b0;
  end
endmodule : bms_lamp_model

`default_nettype wire

//--- dv/bms_mode_timer_bench.sv
// Self-checking testbench of the ballast mode and strike timer.
`timescale 1ns/1ps
`default_nettype none

module bms_mode_timer_bench;
  localparam int TICK = 20;
  localparam int DEAD = 3;
  // Row bits: supply, clear, limit, amp, then expected lockout and buck.
  localparam logic [5:0] ROWS [7] = '{6'b000010, 6'b110010, 6'b100001, 6'b101000, 6'b100100, 6'b100001, 6'b000010};
  logic clk, arst_n, sup, clr, lim, amp, light_en, vlo;
  logic volt_hi, osc, gate, hi1, lo1, hi2, lo2, buck, lock, fault, lit;
  int   bad_count, total_checks, cyc, n, m, t0;

  bms_mode_timer #(.TICK_CYCLES(TICK), .DEAD_CYCLES(DEAD)) bms_mode_timer_i (
    .clk(clk), .arst_n(arst_n), .supply_start_threshold(sup), .fault_clear_hi_in(clr),
    .lamp_volt_hi_in(volt_hi), .lamp_volt_lo_in(vlo), .lamp_volt_limit_in(lim), .lamp_amp_in(amp),
    .bridge_osc_cap(osc), .strike_gate_out(gate), .bridge_hi1_drive(hi1), .bridge_lo1_drive(lo1),
    .bridge_hi2_drive(hi2), .bridge_lo2_drive(lo2), .buck_drive_en(buck), .supply_lockout_mode(lock),
    .fault_mode(fault), .lamp_ignited(lit));

  bms_lamp_model bms_lamp_model_i (
    .clk(clk), .strike_gate_out(gate), .light_en(light_en), .lamp_volt_hi_in(volt_hi), .bridge_osc_cap(osc));

  task automatic check(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Free-running clock and a hang guard well above the longest expected run.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      summarize();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    {sup, clr, lim, amp, light_en, vlo} = 6'h00;
    repeat (6) @(negedge clk);
    check("lockout in reset", 1'b1, lock);
    check("outputs in reset", 1'b0, hi1 | lo1 | buck | gate | fault);
    arst_n = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      {sup, clr, lim, amp} = ROWS[i][5:2];
      repeat (5) @(negedge clk);
      check("lockout", ROWS[i][1], lock);
      check("buck", ROWS[i][0], buck);
    end
    // Strike cadence: one on window of 32 ticks out of 128, cut only by dead times.
    sup = 1'b1;
    n = 0;
    while (lock !== 1'b0 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    t0 = cyc;
    check("gate at ignite entry", 1'b0, gate);
    n = 0;
    repeat (128 * TICK)
    begin
      @(negedge clk);
      n += int'(gate === 1'b1);
    end
    check("gate on time", 1'b1, n inside {[600:645]});
    repeat (60) @(negedge clk);
    check("gate second window", 1'b1, gate);
    // Strike timeout: 1181 ticks in ignite, then the latch holds.
    while (fault !== 1'b1 && cyc - t0 < 30000) @(negedge clk);
    check("fault time", 1'b1, (cyc - t0) inside {[23600:23660]});
    check("power stage and gate in fault", 1'b0, hi1 | lo1 | hi2 | lo2 | gate | buck);
    repeat (50) @(negedge clk);
    check("fault latched", 1'b1, fault);
    clr = 1'b1;
    repeat (5) @(negedge clk);
    check("fault cleared", 1'b0, fault);
    check("lockout after clear", 1'b1, lock);
    clr = 1'b0;
    light_en = 1'b1;
    repeat (5) @(negedge clk);
    check("restart", 1'b0, lock);
    n = 0;
    while (lit !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check("lamp lit", 1'b1, lit);
    // Run longer than one bridge oscillator period, so both diagonals must take their turn.
    n = 0;
    m = 0;
    repeat (TICK * 60)
    begin
      @(negedge clk);
      n += int'(hi1 === 1'b1 && lo2 === 1'b1);
      m += int'(lo1 === 1'b1 && hi2 === 1'b1);
    end
    check("gate after ignition", 1'b0, gate);
    check("both bridge diagonals", 1'b1, n > 0 && m > 0);
    // A lamp that goes out sends the controller back to striking, not to lockout.
    light_en = 1'b0;
    repeat (5) @(negedge clk);
    check("restrike after lamp out", 1'b0, lit | lock);
    light_en = 1'b1;
    n = 0;
    while (lit !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check("lamp relit", 1'b1, lit);
    // Lamp voltage held under the under-voltage level faults after 295 ticks of run.
    vlo = 1'b1;
    n = 0;
    while (fault !== 1'b1 && n < 7000)
    begin
      @(negedge clk);
      n++;
    end
    check("under-voltage fault time", 1'b1, n inside {[5880:5905]});
    check("lamp and buck off in fault", 1'b0, lit | gate | buck);
    summarize();
  end
endmodule : bms_mode_timer_bench

`default_nettype wire
